// file: hdl/rcs_radio_ctrl.sv
// Serial control loader, mode decoder and PA sequencing for the radio
`timescale 1ns/100ps
`default_nettype none

module rcs_radio_ctrl #(
  parameter int unsigned PA_LEAD_CYC = rcs_pkg::PA_LEAD_CYC,
  parameter int unsigned TX_RAMP_CYC = rcs_pkg::TX_RAMP_CYC,
  parameter bit          MSB_FIRST   = 1'b1
) (
  input  wire logic        ref_clk,
  input  wire logic        rst_n,
  input  wire logic        ser_clk,
  input  wire logic        ser_en,
  input  wire logic        ser_data,
  input  wire logic        chip_enable_in,
  input  wire logic        rx_tx_select_in,
  input  wire logic        pll_locked,
  input  wire logic        ref_sel_half,
  output logic             power_amp_enable_out,
  output logic             tx_rf_output,
  output logic             bias_on,
  output logic             rx_on,
  output logic             ref_div_sel,
  output logic [63:0]      ctrl_regs
);

  // Lead of one cycle would let RF drop right behind PA
  if (PA_LEAD_CYC < 2 || PA_LEAD_CYC > 65535 ||
      TX_RAMP_CYC < 1 || TX_RAMP_CYC > 65535) begin : g_bad_cycles
    $error("rcs_radio_ctrl: cycle counts out of range");
  end

  // ---------------------------------------------------------------
  // Serial shift register on the bus clock
  // ---------------------------------------------------------------
  logic [15:0] shift;

  always_ff @(posedge ser_clk or negedge rst_n) begin
    if (!rst_n) begin
      shift <= 16'h0000;
    end else if (!ser_en) begin
      if (MSB_FIRST) begin
        shift <= {shift[14:0], ser_data};
      end else begin
        shift <= {ser_data, shift[15:1]};
      end
    end
  end

  // Word stands still while enable is high, so it is read after the rise is seen
  // ---------------------------------------------------------------
  // Enable edge crossing into ref_clk
  // ---------------------------------------------------------------
  logic [2:0] en_sync;
  logic       en_rise;

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      en_sync <= 3'b111;
    end else begin
      en_sync <= {en_sync[1:0], ser_en};
    end
  end

  assign en_rise = en_sync[1] && !en_sync[2];

  rcs_pkg::rcs_load_t load;
  always_comb begin
    load.word = shift;
    load.addr = shift[rcs_pkg::ADDR_POS +: rcs_pkg::ADDR_BITS];
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_regs <= {4{rcs_pkg::CTRL_REG_RST}};
    end else if (en_rise) begin
      ctrl_regs[load.addr*16 +: 16] <= load.word;
    end
  end

  // ---------------------------------------------------------------
  // Mode lines, synchronised
  // ---------------------------------------------------------------
  logic [1:0] ce_sync;
  logic [1:0] sel_sync;
  logic [1:0] lock_sync;
  logic [1:0] half_sync;

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      ce_sync   <= 2'b00;
      sel_sync  <= 2'b00;
      lock_sync <= 2'b00;
      half_sync <= 2'b00;
    end else begin
      ce_sync   <= {ce_sync[0], chip_enable_in};
      sel_sync  <= {sel_sync[0], rx_tx_select_in};
      lock_sync <= {lock_sync[0], pll_locked};
      half_sync <= {half_sync[0], ref_sel_half};
    end
  end

  // Reference selects PLL/calibration divider
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      ref_div_sel <= rcs_pkg::REF_SEL_RST;
    end else begin
      ref_div_sel <= half_sync[1];
    end
  end

  // ---------------------------------------------------------------
  // Mode state machine
  // ---------------------------------------------------------------
  rcs_pkg::rcs_mode_t mode;
  rcs_pkg::rcs_mode_t next_mode;
  logic [15:0]        ramp_cnt;
  logic [15:0]        lead_cnt;
  logic               want_tx;

  assign want_tx = ce_sync[1] && !sel_sync[1];

  always_comb begin
    next_mode = mode;
    case (mode)
      rcs_pkg::RCS_STANDBY: begin
        if (ce_sync[1]) begin
          next_mode = sel_sync[1] ? rcs_pkg::RCS_RECEIVE : rcs_pkg::RCS_TX_RAMP;
        end
      end
      rcs_pkg::RCS_RECEIVE: begin
        if (!ce_sync[1]) begin
          next_mode = rcs_pkg::RCS_STANDBY;
        end else if (!sel_sync[1]) begin
          next_mode = rcs_pkg::RCS_TX_RAMP;
        end
      end
      rcs_pkg::RCS_TX_RAMP: begin
        if (!want_tx) begin
          next_mode = ce_sync[1] ? rcs_pkg::RCS_RECEIVE : rcs_pkg::RCS_STANDBY;
        end else if (ramp_cnt == 16'(TX_RAMP_CYC - 1)) begin
          next_mode = rcs_pkg::RCS_TX_ON;
        end
      end
      rcs_pkg::RCS_TX_ON: begin
        if (lead_cnt == 16'(PA_LEAD_CYC)) begin
          next_mode = ce_sync[1] ? rcs_pkg::RCS_RECEIVE : rcs_pkg::RCS_STANDBY;
        end
      end
      default: next_mode = rcs_pkg::RCS_STANDBY;
    endcase
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      mode <= rcs_pkg::RCS_STANDBY;
    end else begin
      mode <= next_mode;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      ramp_cnt <= 16'h0000;
    end else if (mode == rcs_pkg::RCS_TX_RAMP) begin
      ramp_cnt <= ramp_cnt + 16'h0001;
    end else begin
      ramp_cnt <= 16'h0000;
    end
  end

  // Lead timer runs once the slot ends; RF stays until it expires
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      lead_cnt <= 16'h0000;
    end else if (mode == rcs_pkg::RCS_TX_ON && (!want_tx || lead_cnt != 16'h0000)) begin
      lead_cnt <= lead_cnt + 16'h0001;
    end else begin
      lead_cnt <= 16'h0000;
    end
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  rcs_pkg::rcs_power_t pwr;
  always_comb begin
    pwr.bias_on = (next_mode != rcs_pkg::RCS_STANDBY);
    pwr.rx_on   = (next_mode == rcs_pkg::RCS_RECEIVE);
    pwr.tx_rf   = (next_mode == rcs_pkg::RCS_TX_ON);
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      bias_on              <= 1'b0;
      rx_on                <= 1'b0;
      tx_rf_output         <= 1'b0;
      power_amp_enable_out <= 1'b0;
    end else begin
      bias_on              <= pwr.bias_on;
      rx_on                <= pwr.rx_on;
      tx_rf_output         <= pwr.tx_rf;
      power_amp_enable_out <= pwr.tx_rf && want_tx && lead_cnt == 16'h0000
                              && lock_sync[1];
    end
  end

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  sequence pa_drops;
    power_amp_enable_out ##1 !power_amp_enable_out;
  endsequence

  AST_PA_NEEDS_RF: assert property (@(posedge ref_clk) disable iff (!rst_n)
    power_amp_enable_out |-> tx_rf_output)
    else $error("PA enabled without RF");
  AST_PA_LOCK: assert property (@(posedge ref_clk) disable iff (!rst_n)
    !lock_sync[1] |=> !power_amp_enable_out)
    else $error("PA enabled without lock");
  AST_PA_LEAD: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (pa_drops ##0 lock_sync[1]) |=> (tx_rf_output || !lock_sync[1]))
    else $error("RF removed with PA");
  AST_STANDBY: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (!ce_sync[1] && mode != rcs_pkg::RCS_TX_ON) |=> !bias_on)
    else $error("Bias on in standby");
  AST_RX_MODE: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (ce_sync[1] && sel_sync[1] && mode == rcs_pkg::RCS_RECEIVE) |=> rx_on)
    else $error("Receive not decoded");
  AST_SWITCH: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (mode == rcs_pkg::RCS_RECEIVE && ce_sync[1] && !sel_sync[1]) |=> !rx_on)
    else $error("No switch to transmit");
  AST_LOAD: assert property (@(posedge ref_clk) disable iff (!rst_n)
    en_rise |=> ctrl_regs[$past(load.addr)*16 +: 16] == $past(load.word))
    else $error("Word not loaded");
  AST_HOLD: assert property (@(posedge ser_clk) disable iff (!rst_n)
    ($past(ser_en) && ser_en) |-> $stable(shift))
    else $error("Shift moved while enable high");

endmodule

`default_nettype wire

// file: hdl/rcs_pkg.sv
// Constants and carrier types for the radio control serial and mode block
package rcs_pkg;
  localparam int unsigned WORD_BITS     = 16;
  localparam int unsigned ADDR_BITS     = 2;
  localparam int unsigned ADDR_POS      = 14;
  localparam int unsigned NUM_REGS      = 4;
  localparam int unsigned REF_CLK_MHZ   = 125;
  localparam int unsigned PA_LEAD_US    = 5;
  localparam int unsigned PA_LEAD_CYC   = PA_LEAD_US * REF_CLK_MHZ;
  localparam int unsigned TX_RAMP_US    = 1;
  localparam int unsigned TX_RAMP_CYC   = TX_RAMP_US * REF_CLK_MHZ;
  localparam logic [15:0] CTRL_REG_RST  = 16'h0000;
  localparam logic        REF_SEL_RST   = 1'b0;

  typedef enum logic [1:0] {
    RCS_STANDBY  = 2'b00,
    RCS_RECEIVE  = 2'b01,
    RCS_TX_RAMP  = 2'b10,
    RCS_TX_ON    = 2'b11
  } rcs_mode_t;

  typedef struct packed {
    logic [1:0]  addr;
    logic [15:0] word;
  } rcs_load_t;

  typedef struct packed {
    logic bias_on;
    logic rx_on;
    logic tx_rf;
  } rcs_power_t;
endpackage

// file: testbench/rcs_host_model.sv
// Host side model driving the three-wire control bus
`timescale 1ns/100ps
`default_nettype none

module rcs_host_model (
  output logic ser_clk,
  output logic ser_en,
  output logic ser_data
);
  localparam realtime HALF = 62.5;

  initial begin
    ser_clk  = 1'b0;
    ser_en   = 1'b1;
    ser_data = 1'b0;
  end

  // One framed word, bus clock still outside the frame
  task automatic send(input logic [15:0] w);
    ser_en = 1'b0;
    for (int i = 15; i >= 0; i--) begin
      ser_data = w[i];
      #HALF;
      ser_clk = 1'b1;
      #HALF;
      ser_clk = 1'b0;
    end
    #HALF;
    ser_en   = 1'b1;
    ser_data = ~w[0];
  endtask

  // Clock and data toggled with enable high; loader must ignore them
  task automatic noise();
    for (int i = 0; i < 4; i++) begin
      ser_data = ~ser_data;
      #HALF;
      ser_clk = 1'b1;
      #HALF;
      ser_clk = 1'b0;
    end
  endtask
endmodule

`default_nettype wire

// file: testbench/test_radio_control_serial_and_mode.sv
// Testbench for the radio control serial loader and mode logic
`timescale 1ns/100ps
`default_nettype none

module test_radio_control_serial_and_mode;
  localparam int unsigned LEAD = 8;
  localparam int unsigned RAMP = 4;
  logic        ref_clk;
  logic        rst_n;
  logic        chip_enable_in;
  logic        rx_tx_select_in;
  logic        pll_locked;
  logic        ref_sel_half;
  logic        pa;
  logic        rf;
  logic        bias;
  logic        rx;
  logic        div;
  logic [63:0] regs;
  wire logic   ser_clk;
  wire logic   ser_en;
  wire logic   ser_data;
  int          n_fail;
  int          n_tests;

  rcs_host_model host (.ser_clk(ser_clk), .ser_en(ser_en), .ser_data(ser_data));

  rcs_radio_ctrl #(.PA_LEAD_CYC(LEAD), .TX_RAMP_CYC(RAMP), .MSB_FIRST(1'b1)) dut (
    .ref_clk(ref_clk), .rst_n(rst_n), .ser_clk(ser_clk), .ser_en(ser_en),
    .ser_data(ser_data), .chip_enable_in(chip_enable_in),
    .rx_tx_select_in(rx_tx_select_in), .pll_locked(pll_locked),
    .ref_sel_half(ref_sel_half), .power_amp_enable_out(pa), .tx_rf_output(rf),
    .bias_on(bias), .rx_on(rx), .ref_div_sel(div), .ctrl_regs(regs));

  initial begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask

  task automatic check_bit(input logic got, input logic exp, input string msg);
    n_tests++;
    if (got !== exp) begin
      n_fail++;
      $display("FAIL %0t %s got %b", $time, msg, got);
    end
  endtask

  task automatic check_word(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_fail++;
      $display("FAIL %0t word got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic end_sim();
    $display("checks %0d failures %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // Each address loaded, last write to address 0 overwrites it
  task automatic test_serial();
    logic [15:0] w [5] = '{16'h1234, 16'h5A5A, 16'hA5C3, 16'hFFFF, 16'h3FFE};
    logic [15:0] e [4] = '{16'h3FFE, 16'h5A5A, 16'hA5C3, 16'hFFFF};
    for (int i = 0; i < 5; i++) begin
      host.send(w[i]);
      tick(6);
    end
    host.noise();
    tick(6);
    for (int a = 0; a < 4; a++) begin
      check_word(regs[16*a +: 16], e[a]);
    end
  endtask

  task automatic test_modes();
    chip_enable_in = 1'b0;
    tick(6);
    check_bit(bias, 1'b0, "bias in standby");
    check_bit(rx, 1'b0, "rx in standby");
    chip_enable_in  = 1'b1;
    rx_tx_select_in = 1'b1;
    ref_sel_half    = 1'b1;
    tick(6);
    check_bit(bias, 1'b1, "bias on");
    check_bit(rx, 1'b1, "receive");
    check_bit(pa, 1'b0, "pa in receive");
    check_bit(div, 1'b1, "half ref");
    ref_sel_half = 1'b0;
    tick(6);
    check_bit(div, 1'b0, "full ref");
  endtask

  task automatic test_tx();
    int cnt;
    int k;
    rx_tx_select_in = 1'b0;
    tick(RAMP + 8);
    check_bit(rx, 1'b0, "rx off in tx");
    check_bit(rf, 1'b1, "tx rf");
    check_bit(pa, 1'b1, "pa with rf");
    pll_locked = 1'b0;
    tick(6);
    check_bit(pa, 1'b0, "pa unlocked");
    pll_locked = 1'b1;
    tick(6);
    check_bit(pa, 1'b1, "pa relocked");
    rx_tx_select_in = 1'b1;
    cnt = 0;
    for (k = 0; k < 60 && !(rf === 1'b0); k++) begin
      tick(1);
      if (pa === 1'b0 && rf === 1'b1) cnt++;
    end
    if (k == 60) begin
      n_fail++;
      $display("FAIL %0t rf never removed", $time);
    end
    check_bit(cnt == LEAD, 1'b1, "pa lead");
    tick(6);
    check_bit(rx, 1'b1, "back to receive");
  endtask

  // Reset mid-run clears registers and power; loader works after release
  task automatic test_reset();
    rst_n = 1'b0;
    tick(1);
    check_word(regs[15:0], rcs_pkg::CTRL_REG_RST);
    check_bit(bias, 1'b0, "bias in reset");
    check_bit(rx, 1'b0, "rx in reset");
    rst_n = 1'b1;
    tick(6);
    check_bit(rx, 1'b1, "receive after reset");
    host.send(16'h4321);
    tick(6);
    check_word(regs[31:16], 16'h4321);
    check_word(regs[63:48], rcs_pkg::CTRL_REG_RST);
  endtask

  initial begin
    n_fail = 0;
    n_tests = 0;
    rst_n = 1'b0;
    chip_enable_in = 1'b0;
    rx_tx_select_in = 1'b1;
    pll_locked = 1'b1;
    ref_sel_half = 1'b0;
    tick(6);
    rst_n = 1'b1;
    tick(2);
    test_serial();
    test_modes();
    test_tx();
    test_reset();
    end_sim();
  end
endmodule

`default_nettype wire
